// ===== bench/bsr_jtag_ctl.sv
// test controller model that drives the four-wire test port
`timescale 1ns/1ps
module bsr_jtag_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  localparam int HALF_NS = 100;
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ****************************************
  // frame tasks
  // ****************************************
  // tms and tdi move with the tck fall so they are steady at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    #HALF_NS;
    q = tdo;
    tck <= 1'b1;
    #HALF_NS;
  endtask
  // tdi toggles outside shift so a stale level never passes for data
  task automatic reset_tap;
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
  // from idle: capture, shift n bits, update, idle; tck then stands high
  task automatic shift(input logic ir, input int n,
                       input logic [88:0] din, output logic [88:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) begin
      step(1'b1, ~tdi, q);
    end
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    // margin for the synchroniser before anyone looks at the effect
    #57;
  endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the boundary-scan test port block
`timescale 1ns/1ps
module testbench;
  import bsr_pkg::*;
  localparam logic [3:0] VER = 4'h0;
  localparam logic [15:0] PART = 16'h5a3c; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2a6; // arbitrary value
  localparam int TO_LONG = 32;
  localparam logic [31:0] ID_WORD = {VER, PART, MAKER, 1'b1};
  localparam logic [43:0] PD = 44'h0ff_00ff_0f0f;
  localparam logic [43:0] PL = 44'h333_cccc_3333;
  localparam logic [43:0] PI = 44'h9c3_6a5f_0e71;
  localparam logic [43:0] K1 = 44'h5a5_5a5a_a5a5;
  localparam logic [43:0] V1 = 44'h3c3_c3c3_3c3c;
  localparam logic [43:0] K2 = 44'hfff_0000_ffff;
  localparam logic [43:0] V2 = 44'h0f0_f0f0_f0f0;
  typedef struct {
    logic [3:0] op;
    int len;
    logic [88:0] din;
    logic [88:0] dout;
  } bsr_tb_row_t;
  bsr_tb_row_t rows [4] = '{
    '{BSR_OP_IDCODE, 32, 89'h0, 89'(ID_WORD)},
    '{BSR_OP_IDCODE, 33, 89'h1, {57'h1, ID_WORD}},
    '{BSR_OP_BYPASS, 8, 89'hb5, 89'h6a},
    '{BSR_OP_BYPASS, 1, 89'h1, 89'h0}
  };
  logic sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe;
  logic test_port_enable_fuse, clock_output_fuse, timeout_fuse;
  logic global_pullup_disable, reset_pin_n, chip_reset;
  logic clock_out_enable, test_port_active, reg_wr, reg_rd;
  logic [BSR_PINS-1:0] pin_in, pin_out, pin_oe, pin_pullup_enable;
  logic [BSR_PINS-1:0] pin_output_latch, pin_direction_bit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [88:0] sh;
  int err_count = 0;
  int num_checks = 0;
  int n;
  bsr_tap #(.VERSION(VER), .PART_NUMBER(PART), .MAKER_ID(MAKER),
            .TIMEOUT_LONG(TO_LONG)) bsr_tap_i (
    .sys_clk, .reset_n, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .test_port_enable_fuse, .clock_output_fuse, .timeout_fuse,
    .pin_in, .pin_out, .pin_oe, .pin_pullup_enable, .pin_output_latch,
    .pin_direction_bit, .global_pullup_disable, .reset_pin_n, .chip_reset,
    .clock_out_enable, .test_port_active, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata
  );
  bsr_jtag_ctl bsr_jtag_ctl_i (.tck, .tms, .tdi, .tdo);
  always #12.5 sys_clk = ~sys_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [88:0] seen, input logic [88:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bsr_jtag_ctl_i.reset_tap();
  endtask
  task automatic ir(input logic [3:0] op);
    bsr_jtag_ctl_i.shift(1'b1, BSR_IR_W, 89'(op), sh);
    check(sh, 89'(BSR_IR_CAPTURE));
  endtask
  // control at 2p below the reset cell, one place higher above it
  function automatic logic [88:0] chain_of(input logic [43:0] ctl,
                                           input logic [43:0] dat,
                                           input logic rst);
    int c;
    chain_of = '0;
    for (int p = 0; p < BSR_PINS; p++) begin
      c = (p < 31) ? 2 * p : 2 * p + 1;
      chain_of[c] = ctl[p];
      chain_of[c + 1] = dat[p];
    end
    chain_of[BSR_RST_CELL] = rst;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    test_port_enable_fuse = 1'b1;
    clock_output_fuse = 1'b1;
    timeout_fuse = 1'b1;
    global_pullup_disable = 1'b0;
    reset_pin_n = 1'b1;
    pin_in = '0;
    pin_output_latch = '0;
    pin_direction_bit = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    do_reset();
    bus_rd(BSR_ADDR_MCU_CONTROL, rd);
    check(rd, BSR_MCU_CONTROL_RST);
    bus_rd(BSR_ADDR_RESET_CAUSE, rd);
    check(rd, BSR_RESET_CAUSE_RST);
    bus_rd(8'h07, rd);
    check(rd, 8'h00);
    bsr_jtag_ctl_i.shift(1'b0, BSR_ID_W, '0, sh);
    check(sh, 89'(ID_WORD));
    foreach (rows[i]) begin
      ir(rows[i].op);
      bsr_jtag_ctl_i.shift(1'b0, rows[i].len, rows[i].din, sh);
      check(sh, rows[i].dout);
    end
    // pins observed through preload, then driven by extest
    pin_direction_bit <= PD;
    pin_output_latch <= PL;
    pin_in <= PI;
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(pin_out, PL);
    check(pin_oe, PD);
    check(pin_pullup_enable, ~PD & PL);
    check(clock_out_enable, 1'b1);
    ir(BSR_OP_PRELOAD);
    check(pin_pullup_enable, '0);
    check(clock_out_enable, 1'b0);
    bsr_jtag_ctl_i.shift(1'b0, BSR_CHAIN_W, chain_of(K1, V1, 1'b0), sh);
    check(sh, chain_of(PD, PI, 1'b0));
    check(pin_out, PL);
    check(pin_oe, PD);
    ir(BSR_OP_EXTEST);
    check(pin_out, V1);
    check(pin_oe, K1);
    bsr_jtag_ctl_i.shift(1'b0, BSR_CHAIN_W, chain_of(K2, V2, 1'b1), sh);
    check(sh, chain_of(PD, PI, 1'b0));
    check(pin_out, V2);
    check(pin_oe, K2);
    check(pin_pullup_enable, '0);
    reset_pin_n <= 1'b1;
    // reset register: held, flagged, then released with time-out
    ir(BSR_OP_CHIPRST);
    bsr_jtag_ctl_i.shift(1'b0, 1, 89'h1, sh);
    check(chip_reset, 1'b1);
    check(pin_oe, '0);
    bus_wr(BSR_ADDR_RESET_CAUSE, 8'h00);
    bus_rd(BSR_ADDR_RESET_CAUSE, rd);
    check(rd & 8'h10, 8'h10);
    bsr_jtag_ctl_i.shift(1'b0, 1, 89'h0, sh);
    check(sh, 89'h1);
    check(chip_reset, 1'b1);
    n = 0;
    while (chip_reset === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    check(n > 0 && n <= TO_LONG, 1'b1);
    bus_wr(BSR_ADDR_RESET_CAUSE, 8'h00);
    bus_rd(BSR_ADDR_RESET_CAUSE, rd);
    check(rd, 8'h00);
    // disable bit: a late second write only re-arms
    bus_wr(BSR_ADDR_MCU_CONTROL, 8'h80);
    repeat (8) @(posedge sys_clk);
    bus_wr(BSR_ADDR_MCU_CONTROL, 8'h80);
    check(test_port_active, 1'b1);
    bus_wr(BSR_ADDR_MCU_CONTROL, 8'h80);
    repeat (2) @(posedge sys_clk);
    check(test_port_active, 1'b0);
    bus_rd(BSR_ADDR_MCU_CONTROL, rd);
    check(rd, 8'h80);
    bus_wr(BSR_ADDR_MCU_CONTROL, 8'h00);
    check(test_port_active, 1'b0);
    bus_wr(BSR_ADDR_MCU_CONTROL, 8'h00);
    repeat (2) @(posedge sys_clk);
    check(test_port_active, 1'b1);
    test_port_enable_fuse <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(test_port_active, 1'b0);
    test_port_enable_fuse <= 1'b1;
    // a fresh reset brings back the identification instruction
    do_reset();
    bsr_jtag_ctl_i.shift(1'b0, BSR_ID_W, '0, sh);
    check(sh, 89'(ID_WORD));
    complete_run();
  end
  initial begin
    #1_000_000;
    err_count++;
    complete_run();
  end
endmodule

// ===== design/bsr_pkg.sv
// constants and types for the boundary-scan test port block
// Contract
// [R1] instruction register is four bits wide
// [R2] every shift register moves least significant bit first in and out
// [R3] opcode 0x0 selects chain; latched outputs drive pins once loaded
// [R4] extest: capture samples pins, shift moves chain, update drives pins
// [R5] opcode 0x1 selects 32-bit id; default after reset; capture loads id
// [R6] id holds 4-bit version, 16-bit part, 11-bit maker fields
// [R7] version equals silicon revision, first revision zero
// [R8] opcode 0x2: capture samples, update loads latches without pins
// [R9] opcode 0xc selects one-bit reset register; state machine untouched
// [R10] chip held in reset while reset register holds one, unlatched
// [R11] after release chip stays reset for fuse-selected time-out
// [R12] opcode 0xf selects bypass; capture loads zero; shift passes through
// [R13] no high-impedance instruction; reset register tri-states pins
// [R14] control bit 7 disables the port; zero plus fuse enables it
// [R15] disable bit changes only on same value written twice in four cycles
// [R16] status bit 4 set by reset-register reset, cleared by por or zero
// [R17] pull-ups off while extest or instr_a loaded
// [R18] pin cell: data stage first flop, control stage second
// [R19] cell sources are pin, port latch, direction; pull-up rule fixed
// [R20] clock not driven out under extest or instr_a
// [R21] reset pin seen through observe-only cell
// [R22] chain bit 0 first up to bit 88 in pin-out order
// [R23] port f bits 4 to 7 and usb pads not in chain
// [R24] bypass is one stage cleared at capture when selected
// [R25] port enabled only with fuse programmed and disable bit clear
// [R26] id word: version 31:28, part 27:12, maker 11:1, bit 0 one
// [R27] standard sixteen-state machine on tck rise, tdo on tck fall
package bsr_pkg;
  localparam int BSR_IR_W = 4;
  localparam logic [3:0] BSR_OP_EXTEST = 4'h0;
  localparam logic [3:0] BSR_OP_IDCODE = 4'h1;
  localparam logic [3:0] BSR_OP_PRELOAD = 4'h2;
  localparam logic [3:0] BSR_OP_CHIPRST = 4'hc;
  localparam logic [3:0] BSR_OP_BYPASS = 4'hf;
  localparam logic [3:0] BSR_IR_CAPTURE = 4'h1;
  localparam int BSR_ID_W = 32;
  localparam int BSR_CHAIN_W = 89;
  localparam int BSR_PINS = 44;
  localparam int BSR_RST_CELL = 62;
  localparam logic [7:0] BSR_ADDR_MCU_CONTROL = 8'h00;
  localparam logic [7:0] BSR_ADDR_RESET_CAUSE = 8'h01;
  localparam int BSR_DISABLE_BIT = 7;
  localparam int BSR_TRF_BIT = 4;
  localparam logic [7:0] BSR_MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] BSR_RESET_CAUSE_RST = 8'h00;
  localparam logic [2:0] BSR_DOUBLE_WR_WIN = 3'h4;
  typedef enum logic [3:0] {
    BSR_RESET = 4'b0000, BSR_IDLE = 4'b0001, BSR_SEL_DR = 4'b0010,
    BSR_CAP_DR = 4'b0011, BSR_SH_DR = 4'b0100, BSR_EX1_DR = 4'b0101,
    BSR_PAU_DR = 4'b0110, BSR_EX2_DR = 4'b0111, BSR_UPD_DR = 4'b1000,
    BSR_SEL_IR = 4'b1001, BSR_CAP_IR = 4'b1010, BSR_SH_IR = 4'b1011,
    BSR_EX1_IR = 4'b1100, BSR_PAU_IR = 4'b1101, BSR_EX2_IR = 4'b1110,
    BSR_UPD_IR = 4'b1111
  } bsr_state_t;
endpackage

// ===== design/bsr_tap.sv
// boundary-scan test port, data registers and control registers
`timescale 1ns/1ps
module bsr_tap #(
  parameter logic [3:0] VERSION = 4'h0,
  parameter logic [15:0] PART_NUMBER = 16'h1234, // arbitrary value
  parameter logic [10:0] MAKER_ID = 11'h055, // arbitrary value
  parameter int TIMEOUT_SHORT = 16,
  parameter int TIMEOUT_LONG = 8192
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic test_port_enable_fuse,
  input wire logic clock_output_fuse,
  input wire logic timeout_fuse,
  input wire logic [bsr_pkg::BSR_PINS-1:0] pin_in,
  output logic [bsr_pkg::BSR_PINS-1:0] pin_out,
  output logic [bsr_pkg::BSR_PINS-1:0] pin_oe,
  output logic [bsr_pkg::BSR_PINS-1:0] pin_pullup_enable,
  input wire logic [bsr_pkg::BSR_PINS-1:0] pin_output_latch,
  input wire logic [bsr_pkg::BSR_PINS-1:0] pin_direction_bit,
  input wire logic global_pullup_disable,
  input wire logic reset_pin_n,
  output logic chip_reset,
  output logic clock_out_enable,
  output logic test_port_active,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import bsr_pkg::*;

  // ************************************************************
  // reset release and pin synchronisers
  // ************************************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  logic [2:0] tp_s1_ff, tp_s2_ff;
  logic tck_d_ff;
  logic [BSR_PINS:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tp_s1_ff <= 3'h0;
      tp_s2_ff <= 3'h0;
      tck_d_ff <= 1'b0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      tp_s1_ff <= {tck, tms, tdi};
      tp_s2_ff <= tp_s1_ff;
      tck_d_ff <= tp_s2_ff[2];
      pin_s1_ff <= {reset_pin_n, pin_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  logic tck_rise, tck_fall, tms_s, tdi_s;
  assign tck_rise = tp_s2_ff[2] & ~tck_d_ff;
  assign tck_fall = ~tp_s2_ff[2] & tck_d_ff;
  assign tms_s = tp_s2_ff[1];
  assign tdi_s = tp_s2_ff[0];

  // ************************************************************
  // control registers
  // ************************************************************
  logic [7:0] mcu_control_ff, reset_cause_status_ff;
  logic [2:0] arm_cnt_ff;
  logic arm_val_ff;
  logic wr_ctl, wr_cause, trf_set;
  assign wr_ctl = reg_wr && reg_addr == BSR_ADDR_MCU_CONTROL;
  assign wr_cause = reg_wr && reg_addr == BSR_ADDR_RESET_CAUSE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcu_control_ff <= BSR_MCU_CONTROL_RST;
      arm_cnt_ff <= 3'h0;
      arm_val_ff <= 1'b0;
    end else if (wr_ctl) begin
      mcu_control_ff[6:0] <= reg_wdata[6:0];
      // second matching write inside the window commits
      if (arm_cnt_ff != 3'h0 && arm_val_ff == reg_wdata[BSR_DISABLE_BIT]) begin
        mcu_control_ff[BSR_DISABLE_BIT] <= reg_wdata[BSR_DISABLE_BIT]; // [R15]
        arm_cnt_ff <= 3'h0;
      end else begin
        arm_cnt_ff <= BSR_DOUBLE_WR_WIN;
        arm_val_ff <= reg_wdata[BSR_DISABLE_BIT];
      end
    end else if (arm_cnt_ff != 3'h0) begin
      arm_cnt_ff <= arm_cnt_ff - 3'h1;
    end
  end

  // por clears the flag; a set in the same cycle as a clear wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) reset_cause_status_ff <= BSR_RESET_CAUSE_RST;
    else begin
      if (wr_cause) reset_cause_status_ff <= reg_wdata;
      if (trf_set) reset_cause_status_ff[BSR_TRF_BIT] <= 1'b1; // [R16]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      unique case (reg_addr)
        BSR_ADDR_MCU_CONTROL: reg_rdata <= mcu_control_ff;
        BSR_ADDR_RESET_CAUSE: reg_rdata <= reset_cause_status_ff;
        default: reg_rdata <= 8'h00;
      endcase
    end else reg_rdata <= 8'h00;
  end

  logic port_en;
  assign port_en = test_port_enable_fuse
    && !mcu_control_ff[BSR_DISABLE_BIT]; // [R14] [R25]
  assign test_port_active = port_en;

  // ************************************************************
  // test-port state machine
  // ************************************************************
  bsr_state_t st_ff, nxt_st;
  always_comb begin
    unique case (st_ff)
      BSR_RESET: nxt_st = tms_s ? BSR_RESET : BSR_IDLE;
      BSR_IDLE: nxt_st = tms_s ? BSR_SEL_DR : BSR_IDLE;
      BSR_SEL_DR: nxt_st = tms_s ? BSR_SEL_IR : BSR_CAP_DR;
      BSR_CAP_DR: nxt_st = tms_s ? BSR_EX1_DR : BSR_SH_DR;
      BSR_SH_DR: nxt_st = tms_s ? BSR_EX1_DR : BSR_SH_DR;
      BSR_EX1_DR: nxt_st = tms_s ? BSR_UPD_DR : BSR_PAU_DR;
      BSR_PAU_DR: nxt_st = tms_s ? BSR_EX2_DR : BSR_PAU_DR;
      BSR_EX2_DR: nxt_st = tms_s ? BSR_UPD_DR : BSR_SH_DR;
      BSR_UPD_DR: nxt_st = tms_s ? BSR_SEL_DR : BSR_IDLE;
      BSR_SEL_IR: nxt_st = tms_s ? BSR_RESET : BSR_CAP_IR;
      BSR_CAP_IR: nxt_st = tms_s ? BSR_EX1_IR : BSR_SH_IR;
      BSR_SH_IR: nxt_st = tms_s ? BSR_EX1_IR : BSR_SH_IR;
      BSR_EX1_IR: nxt_st = tms_s ? BSR_UPD_IR : BSR_PAU_IR;
      BSR_PAU_IR: nxt_st = tms_s ? BSR_EX2_IR : BSR_PAU_IR;
      BSR_EX2_IR: nxt_st = tms_s ? BSR_UPD_IR : BSR_SH_IR;
      BSR_UPD_IR: nxt_st = tms_s ? BSR_SEL_DR : BSR_IDLE;
    endcase
  end
  // a disabled port is parked in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) st_ff <= BSR_RESET;
    else if (!port_en) st_ff <= BSR_RESET;
    else if (tck_rise) st_ff <= nxt_st; // [R27]
  end

  // ************************************************************
  // instruction register
  // ************************************************************
  logic [BSR_IR_W-1:0] ir_sr_ff, ir_ff; // [R1]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sr_ff <= BSR_IR_CAPTURE;
      ir_ff <= BSR_OP_IDCODE;
    end else if (st_ff == BSR_RESET) begin
      ir_ff <= BSR_OP_IDCODE; // [R5]
    end else if (tck_rise) begin
      if (st_ff == BSR_CAP_IR) ir_sr_ff <= BSR_IR_CAPTURE;
      if (st_ff == BSR_SH_IR)
        ir_sr_ff <= {tdi_s, ir_sr_ff[BSR_IR_W-1:1]}; // [R2]
      if (st_ff == BSR_UPD_IR) ir_ff <= ir_sr_ff;
    end
  end

  logic sel_chain, sel_id, sel_rst, scan_mode, extest;
  assign extest = ir_ff == BSR_OP_EXTEST;
  assign scan_mode = extest || ir_ff == BSR_OP_PRELOAD; // [R8]
  assign sel_chain = scan_mode; // [R3]
  assign sel_id = ir_ff == BSR_OP_IDCODE;
  assign sel_rst = ir_ff == BSR_OP_CHIPRST; // [R9]

  // ************************************************************
  // data registers
  // ************************************************************
  localparam logic [BSR_ID_W-1:0] ID_WORD =
    {VERSION, PART_NUMBER, MAKER_ID, 1'b1}; // [R6] [R7] [R26]

  // position of each pin's control cell; reset cell sits in between
  function automatic int ctl_pos(input int p);
    return (2 * p < BSR_RST_CELL) ? 2 * p : 2 * p + 1; // [R22] [R21]
  endfunction

  logic [BSR_CHAIN_W-1:0] dr_sr_ff, cap_val, nxt_dr;
  logic [BSR_PINS-1:0] upd_dat_ff, upd_ctl_ff;
  logic bypass_ff, rst_reg_ff;
  int dr_len;
  always_comb begin
    dr_len = 1;
    if (sel_chain) dr_len = BSR_CHAIN_W;
    else if (sel_id) dr_len = BSR_ID_W;
  end

  // chain excludes port f 4..7 and usb pads; those are simply not wired
  assign cap_val[BSR_RST_CELL] = pin_s2_ff[BSR_PINS]; // [R21] [R23]
  genvar g;
  generate
    for (g = 0; g < BSR_PINS; g++) begin : g_pin
      // control stage sits below data stage in shift order
      assign cap_val[ctl_pos(g)] = pin_direction_bit[g]; // [R18]
      assign cap_val[ctl_pos(g) + 1] = pin_s2_ff[g]; // [R4] [R19]
    end
    for (g = 0; g < BSR_CHAIN_W; g++) begin : g_sh
      always_comb begin
        if (g == dr_len - 1) nxt_dr[g] = tdi_s; // [R2]
        else if (g == BSR_CHAIN_W - 1) nxt_dr[g] = 1'b0;
        else nxt_dr[g] = dr_sr_ff[g + 1];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) dr_sr_ff <= '0;
    else if (tck_rise && st_ff == BSR_CAP_DR) begin
      if (sel_chain) dr_sr_ff <= cap_val; // [R4] [R8]
      else if (sel_id) dr_sr_ff <= BSR_CHAIN_W'(ID_WORD); // [R5]
    end else if (tck_rise && st_ff == BSR_SH_DR && (sel_chain || sel_id))
      dr_sr_ff <= nxt_dr; // [R4]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) bypass_ff <= 1'b0;
    else if (tck_rise && !sel_chain && !sel_id && !sel_rst) begin
      if (st_ff == BSR_CAP_DR) bypass_ff <= 1'b0; // [R12] [R24]
      else if (st_ff == BSR_SH_DR) bypass_ff <= tdi_s; // [R12]
    end
  end

  // not latched: a one shifted in asserts reset at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rst_reg_ff <= 1'b0;
    else if (!port_en) rst_reg_ff <= 1'b0;
    else if (tck_rise && sel_rst && st_ff == BSR_SH_DR)
      rst_reg_ff <= tdi_s; // [R9] [R10]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_dat_ff <= '0;
      upd_ctl_ff <= '0;
    end else if (tck_rise && st_ff == BSR_UPD_DR && sel_chain) begin
      for (int p = 0; p < BSR_PINS; p++) begin
        upd_ctl_ff[p] <= dr_sr_ff[ctl_pos(p)];
        upd_dat_ff[p] <= dr_sr_ff[ctl_pos(p) + 1];
      end
    end
  end

  // ************************************************************
  // output data and reset time-out
  // ************************************************************
  logic tdo_mux;
  always_comb begin
    if (st_ff == BSR_SH_IR) tdo_mux = ir_sr_ff[0];
    else if (sel_chain || sel_id) tdo_mux = dr_sr_ff[0];
    else if (sel_rst) tdo_mux = rst_reg_ff;
    else tdo_mux = bypass_ff;
  end
  logic shifting;
  assign shifting = st_ff == BSR_SH_DR || st_ff == BSR_SH_IR;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= tdo_mux; // [R27]
      tdo_oe <= shifting;
    end
  end

  // long count stays a parameter so a bench can shorten it
  logic [31:0] tmo_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) tmo_ff <= 32'h0;
    else if (rst_reg_ff)
      tmo_ff <= timeout_fuse ? 32'(TIMEOUT_LONG) : 32'(TIMEOUT_SHORT);
    else if (tmo_ff != 32'h0) tmo_ff <= tmo_ff - 32'h1; // [R11]
  end
  assign chip_reset = rst_reg_ff || tmo_ff != 32'h0; // [R10] [R11]
  assign trf_set = rst_reg_ff; // [R16]
  assign clock_out_enable = clock_output_fuse && !scan_mode; // [R20]

  // extest drives pins from the update latches; outside extest reset floats them
  always_comb begin
    for (int p = 0; p < BSR_PINS; p++) begin
      if (extest) begin
        pin_out[p] = upd_dat_ff[p]; // [R3] [R4]
        pin_oe[p] = upd_ctl_ff[p];
      end else begin
        pin_out[p] = pin_output_latch[p]; // [R19]
        pin_oe[p] = pin_direction_bit[p] && !chip_reset; // [R13]
      end
      pin_pullup_enable[p] = !global_pullup_disable && !pin_direction_bit[p]
        && pin_output_latch[p] && !scan_mode; // [R17] [R19]
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_idcode_default;
    @(posedge sys_clk) disable iff (!rst_n)
    st_ff == BSR_RESET |=> ir_ff == BSR_OP_IDCODE;
  endproperty
  a_idcode_default: assert property (p_idcode_default) // [R5]
    else $error("ir not idcode after reset state");
  property p_extest_drive;
    @(posedge sys_clk) disable iff (!rst_n)
    extest |-> pin_out == upd_dat_ff && pin_oe == upd_ctl_ff;
  endproperty
  a_extest_drive: assert property (p_extest_drive) // [R3]
    else $error("extest pins not from latches");
  property p_pullup_off;
    @(posedge sys_clk) disable iff (!rst_n)
    scan_mode |-> pin_pullup_enable == '0;
  endproperty
  a_pullup_off: assert property (p_pullup_off) // [R17]
    else $error("pull-up on in scan mode");
  property p_clk_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    scan_mode |-> !clock_out_enable;
  endproperty
  a_clk_gate: assert property (p_clk_gate) // [R20]
    else $error("clock out in scan mode");
  property p_reset_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(rst_reg_ff) |-> chip_reset [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold) // [R11]
    else $error("reset released before time-out");
  property p_trf_set;
    @(posedge sys_clk) disable iff (!rst_n)
    rst_reg_ff |=> reset_cause_status_ff[BSR_TRF_BIT];
  endproperty
  a_trf_set: assert property (p_trf_set) // [R16]
    else $error("reset flag not set");
  property p_single_write;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_ctl && arm_cnt_ff == 3'h0 |=> $stable(mcu_control_ff[BSR_DISABLE_BIT]);
  endproperty
  a_single_write: assert property (p_single_write) // [R15]
    else $error("disable bit changed on single write");
  property p_bypass_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    tck_rise && st_ff == BSR_CAP_DR && ir_ff == BSR_OP_BYPASS
      |=> !bypass_ff;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) // [R12]
    else $error("bypass not cleared at capture");
  property p_disabled_park;
    @(posedge sys_clk) disable iff (!rst_n)
    !port_en |=> st_ff == BSR_RESET;
  endproperty
  a_disabled_park: assert property (p_disabled_park) // [R25]
    else $error("state machine runs while disabled");
  c_extest: cover property (@(posedge sys_clk) disable iff (!rst_n)
    extest && tck_rise && st_ff == BSR_UPD_DR);
  c_chip_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_reg_ff));
  c_disable: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(mcu_control_ff[BSR_DISABLE_BIT]));
  c_id_shift: cover property (@(posedge sys_clk) disable iff (!rst_n)
    sel_id && tck_rise && st_ff == BSR_SH_DR);
endmodule
